// ===== inc/mpfm_pkg.sv
// package for the mode-dependent pin function multiplexer
// assumes a 32-bit classic wishbone register bus with byte addresses
`default_nettype none

package mpfm_pkg;

  // ----------------------------------------------------------------------
  // operating modes, one-hot
  // ----------------------------------------------------------------------
  typedef enum logic [2:0] {
    MPFM_REPEATER = 3'h1,
    MPFM_ADAPTER  = 3'h2,
    MPFM_TEST     = 3'h4
  } mpfm_mode_type;

  // ----------------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------------
  localparam logic [3:0]  CTRL_ADDR       = 4'h0;
  localparam logic [3:0]  STAT_ADDR       = 4'h4;
  localparam logic [3:0]  CTRL_RESET      = 4'h0;

  // control field positions
  localparam int          CTRL_ADAPTER    = 0;
  localparam int          CTRL_FULL_DUP   = 1;
  localparam int          CTRL_ALT_ADV    = 2;
  localparam int          CTRL_FLOAT_REQ  = 3;

  // status field positions
  localparam int          STAT_MODE_LSB   = 0;
  localparam int          STAT_SPEED100   = 3;
  localparam int          STAT_LEGACY     = 4;
  localparam int          STAT_LINK_OK    = 5;
  localparam int          STAT_TEST_EXEC  = 6;
  localparam int          STAT_SLAVE_OFF  = 7;
  localparam int          STAT_ADDR_LSB   = 8;

  localparam int          PIN_COUNT       = 8;

endpackage

`default_nettype wire

// ===== core/mpfm_pin_sampler.sv
// input register stage for the multiplexed configuration pins
// assumes the pins are synchronous to clk_i
`timescale 1ns/100ps
`default_nettype none

module mpfm_pin_sampler
(
  input  wire logic                          clk_i,
  input  wire logic                          rst_i,
  input  wire logic                          ce_i,
  input  wire logic [mpfm_pkg::PIN_COUNT-1:0] pins_i,
  output logic      [mpfm_pkg::PIN_COUNT-1:0] pins_o
);

  logic [mpfm_pkg::PIN_COUNT-1:0] pins;
  logic [mpfm_pkg::PIN_COUNT-1:0] next_pins;

  always_comb
  begin
    next_pins = pins;
    if (ce_i)
    begin
      next_pins = pins_i;
    end
  end

  // reset value is a constant; pins settle before first use
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      pins <= '0;
    end
    else
    begin
      pins <= next_pins;
    end
  end

  assign pins_o = pins;

endmodule

`default_nettype wire

// ===== core/mpfm_pin_mux.sv
// mode-dependent function multiplexer for shared configuration pins
// assumes synchronous pins, a classic wishbone master, one clock domain
`timescale 1ns/100ps
`default_nettype none

module mpfm_pin_mux
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  // wishbone slave
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [3:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  // shared pins
  input  wire logic        test_enable_i,
  input  wire logic        force_speed_select_i,
  input  wire logic        port_addr_bit4_i,
  input  wire logic        port_addr_bit3_i,
  output logic             port_addr_bit3_o,
  output logic             port_addr_bit3_oe_o,
  input  wire logic        port_addr_bit2_i,
  input  wire logic        port_addr_bit1_i,
  input  wire logic        port_addr_bit0_i,
  // decoded functions
  output logic [2:0]       mode_o,
  output logic             speed_100_o,
  output logic [4:0]       mgmt_addr_o,
  output logic             mac_legacy_fmt_o,
  output logic             slave_off_o,
  output logic             slave_link_ok_o,
  output logic             test_serial_in_o,
  output logic             test_execute_o,
  output logic             test_clock_o
);

  // ----------------------------------------------------------------------
  // pin sampling
  // ----------------------------------------------------------------------
  logic [mpfm_pkg::PIN_COUNT-1:0] pins;
  logic                           s_test_en;
  logic                           s_force;
  logic [4:0]                     s_addr;

  mpfm_pin_sampler u_sampler
  (
    .clk_i  (clk_i),
    .rst_i  (rst_i),
    .ce_i   (ce_i),
    .pins_i ({port_addr_bit4_i, port_addr_bit3_i, port_addr_bit2_i,
              port_addr_bit1_i, port_addr_bit0_i, force_speed_select_i,
              test_enable_i, 1'b0}),
    .pins_o (pins)
  );

  assign s_addr    = pins[7:3];
  assign s_force   = pins[2];
  assign s_test_en = pins[1];

  // ----------------------------------------------------------------------
  // control register and bus slave
  // ----------------------------------------------------------------------
  logic [3:0]  ctrl;
  logic [3:0]  next_ctrl;
  logic        ack;
  logic        next_ack;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [31:0] status;
  logic        req;

  // one wait state: ack the cycle after the request, drop it after that
  assign req = wb_cyc_i & wb_stb_i & ~ack;

  always_comb
  begin
    next_ctrl  = ctrl;
    next_ack   = ack;
    next_rdata = rdata;
    if (ce_i)
    begin
      next_ack = req;
      if (req && wb_we_i && wb_adr_i == mpfm_pkg::CTRL_ADDR && wb_sel_i[0])
      begin
        next_ctrl = wb_dat_i[3:0];
      end
      if (req && !wb_we_i)
      begin
        unique case (wb_adr_i)
          mpfm_pkg::CTRL_ADDR: next_rdata = {28'h0000000, ctrl};
          mpfm_pkg::STAT_ADDR: next_rdata = status;
          // unmapped addresses are acknowledged and read as zero
          default:             next_rdata = 32'h00000000;
        endcase
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      ctrl  <= mpfm_pkg::CTRL_RESET;
      ack   <= 1'b0;
      rdata <= 32'h00000000;
    end
    else
    begin
      ctrl  <= next_ctrl;
      ack   <= next_ack;
      rdata <= next_rdata;
    end
  end

  assign wb_ack_o = ack;
  assign wb_dat_o = rdata;

  // ----------------------------------------------------------------------
  // mode state
  // ----------------------------------------------------------------------
  mpfm_pkg::mpfm_mode_type mode;
  mpfm_pkg::mpfm_mode_type next_mode;

  always_comb
  begin
    next_mode = mode;
    if (ce_i)
    begin
      if (s_test_en)
      begin
        next_mode = mpfm_pkg::MPFM_TEST;
      end
      else if (ctrl[mpfm_pkg::CTRL_ADAPTER])
      begin
        next_mode = mpfm_pkg::MPFM_ADAPTER;
      end
      else
      begin
        next_mode = mpfm_pkg::MPFM_REPEATER;
      end
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      mode <= mpfm_pkg::MPFM_REPEATER;
    end
    else
    begin
      mode <= next_mode;
    end
  end

  // ----------------------------------------------------------------------
  // function decode
  // ----------------------------------------------------------------------
  logic       speed100;
  logic       next_speed100;
  logic [4:0] maddr;
  logic [4:0] next_maddr;
  logic       legacy;
  logic       next_legacy;
  logic       sl_off;
  logic       next_sl_off;
  logic       link_ok;
  logic       next_link_ok;
  logic       tdata;
  logic       next_tdata;
  logic       test_execute;
  logic       next_test_execute;
  logic       tclk;
  logic       next_tclk;
  logic       float_drv;
  logic       alt_adv;

  assign alt_adv   = ctrl[mpfm_pkg::CTRL_ALT_ADV];
  assign float_drv = ctrl[mpfm_pkg::CTRL_FLOAT_REQ];

  // outputs of inactive modes hold their last value, except sl_off, link_ok and test_execute, which clear; speed and address
  // stay latched so leaving repeater mode does not glitch the config
  always_comb
  begin
    next_speed100 = speed100;
    next_maddr    = maddr;
    next_legacy   = legacy;
    next_sl_off   = sl_off;
    next_link_ok  = link_ok;
    next_tdata    = tdata;
    next_test_execute    = test_execute;
    next_tclk     = tclk;
    if (ce_i)
    begin
      next_sl_off  = 1'b0;
      next_link_ok = 1'b0;
      next_test_execute   = 1'b0;
      unique case (mode)
        mpfm_pkg::MPFM_REPEATER:
        begin
          next_speed100 = s_force;
          next_maddr    = s_addr;
        end
        mpfm_pkg::MPFM_ADAPTER:
        begin
          if (ctrl[mpfm_pkg::CTRL_FULL_DUP])
          begin
            next_legacy = s_force;
          end
          next_sl_off  = float_drv & alt_adv;
          next_link_ok = alt_adv & ~s_addr[2];
        end
        mpfm_pkg::MPFM_TEST:
        begin
          next_tdata = s_addr[4];
          next_test_execute = s_addr[1];
          next_tclk  = s_addr[0];
        end
        default:
        begin
          next_test_execute = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      speed100 <= 1'b0;
      maddr    <= 5'h00;
      legacy   <= 1'b0;
      sl_off   <= 1'b0;
      link_ok  <= 1'b0;
      tdata    <= 1'b0;
      test_execute    <= 1'b0;
      tclk     <= 1'b0;
    end
    else
    begin
      speed100 <= next_speed100;
      maddr    <= next_maddr;
      legacy   <= next_legacy;
      sl_off   <= next_sl_off;
      link_ok  <= next_link_ok;
      tdata    <= next_tdata;
      test_execute    <= next_test_execute;
      tclk     <= next_tclk;
    end
  end

  // float control drives the shared pin only in adapter mode
  assign port_addr_bit3_oe_o = (mode == mpfm_pkg::MPFM_ADAPTER);
  assign port_addr_bit3_o    = float_drv;

  // ----------------------------------------------------------------------
  // status word and outputs
  // ----------------------------------------------------------------------
  always_comb
  begin
    status = 32'h00000000;
    status[mpfm_pkg::STAT_MODE_LSB +: 3] = mode;
    status[mpfm_pkg::STAT_SPEED100]      = speed100;
    status[mpfm_pkg::STAT_LEGACY]        = legacy;
    status[mpfm_pkg::STAT_LINK_OK]       = link_ok;
    status[mpfm_pkg::STAT_TEST_EXEC]     = test_execute;
    status[mpfm_pkg::STAT_SLAVE_OFF]     = sl_off;
    status[mpfm_pkg::STAT_ADDR_LSB +: 5] = maddr;
  end

  assign mode_o           = mode;
  assign speed_100_o      = speed100;
  assign mgmt_addr_o      = maddr;
  assign mac_legacy_fmt_o = legacy;
  assign slave_off_o      = sl_off;
  assign slave_link_ok_o  = link_ok;
  assign test_serial_in_o = tdata;
  assign test_execute_o   = test_execute;
  assign test_clock_o     = tclk;

endmodule

`default_nettype wire

// ===== sim/mpfm_slave_phy.sv
// model of the optional slave phy behind the float and link pins
// assumes the bench tells it the alt advance setting it wrote
`timescale 1ns/100ps
`default_nettype none

module mpfm_slave_phy
(
  input  wire logic clk_i,
  input  wire logic float_i,
  input  wire logic float_oe_i,
  input  wire logic alt_i,
  input  wire logic link_up_i,
  output logic      link_ok_n_o
);
  logic next_link_ok_n;

  // the status line has a pull-up, so an idled slave reads as no link
  always_comb
  begin
    next_link_ok_n = !link_up_i;
    if (float_i && float_oe_i && alt_i)
      next_link_ok_n = 1'b1;
  end

  always_ff @(posedge clk_i)
    link_ok_n_o <= next_link_ok_n;
endmodule

`default_nettype wire

// ===== sim/mpfm_props.sv
// assertions on the ports of the pin function multiplexer
// assumes one clock; pins reach outputs two enabled edges later
`timescale 1ns/100ps
`default_nettype none

module mpfm_props
(
  input wire logic       clk_i,
  input wire logic       rst_i,
  input wire logic       ce_i,
  input wire logic       wb_cyc_i,
  input wire logic       wb_stb_i,
  input wire logic       wb_ack_o,
  input wire logic       test_enable_i,
  input wire logic       force_speed_select_i,
  input wire logic       port_addr_bit4_i,
  input wire logic       port_addr_bit3_i,
  input wire logic       port_addr_bit2_i,
  input wire logic       port_addr_bit1_i,
  input wire logic       port_addr_bit0_i,
  input wire logic [2:0] mode_o,
  input wire logic       speed_100_o,
  input wire logic [4:0] mgmt_addr_o,
  input wire logic       mac_legacy_fmt_o,
  input wire logic       slave_off_o,
  input wire logic       slave_link_ok_o,
  input wire logic       test_serial_in_o,
  input wire logic       test_execute_o,
  input wire logic       test_clock_o,
  input wire logic       port_addr_bit3_oe_o
);
  wire logic [4:0] pin_addr = {port_addr_bit4_i, port_addr_bit3_i,
    port_addr_bit2_i, port_addr_bit1_i, port_addr_bit0_i};

  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);

  speed_pin_a: assert property ((ce_i ##1 ce_i && mode_o == 3'h1) |=>
    speed_100_o == $past(force_speed_select_i, 2)) else $error("speed");
  mgmt_addr_a: assert property ((ce_i ##1 ce_i && mode_o == 3'h1) |=>
    mgmt_addr_o == $past(pin_addr, 2)) else $error("address");
  legacy_fmt_a: assert property ((ce_i ##1 ce_i) ##1
    $changed(mac_legacy_fmt_o) |-> $past(mode_o) == 3'h2 &&
    mac_legacy_fmt_o == $past(force_speed_select_i, 2)) else $error("type");
  test_in_a: assert property ((ce_i ##1 ce_i && mode_o == 3'h4) |=>
    test_serial_in_o == $past(port_addr_bit4_i, 2)) else $error("tin");
  test_exec_a: assert property ((ce_i ##1 ce_i) |=> test_execute_o ==
    ($past(port_addr_bit1_i, 2) && $past(mode_o) == 3'h4))
    else $error("test_execute");
  slave_off_a: assert property (slave_off_o |->
    mode_o == 3'h2 || $past(mode_o) == 3'h2) else $error("float");
  link_ok_a: assert property ((ce_i ##1 ce_i) ##1 slave_link_ok_o |->
    !$past(port_addr_bit2_i, 2)) else $error("link");
  test_mode_a: assert property ((ce_i && test_enable_i ##1 ce_i) |=>
    mode_o == 3'h4) else $error("mode");
  bus_ack_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i |=>
    wb_ack_o) else $error("ack");
  test_clk_a: assert property ((ce_i ##1 ce_i && mode_o == 3'h4) |=>
    test_clock_o == $past(port_addr_bit0_i, 2)) else $error("tck");
  float_oe_a: assert property (port_addr_bit3_oe_o ==
    (mode_o == 3'h2)) else $error("float pin");

  cover property (mode_o == 3'h4 && test_execute_o);
  cover property (slave_off_o);
  cover property (slave_link_ok_o && mac_legacy_fmt_o);
endmodule

bind mpfm_pin_mux mpfm_props PROPS (.*);

`default_nettype wire

// ===== sim/testbench.sv
// self-checking bench for the pin function multiplexer
// assumes the package and the slave model are compiled first
`timescale 1ns/100ps
`default_nettype none

module testbench;
  logic        clk_i = 1'b0, rst_i = 1'b1, ce_i = 1'b1;
  logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0;
  logic [3:0]  wb_adr_i = 4'h0, wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o;
  logic        wb_ack_o, test_enable_i = 1'b0, force_speed_select_i = 1'b0;
  logic        port_addr_bit4_i = 1'b0, port_addr_bit3_i = 1'b0;
  logic        port_addr_bit1_i = 1'b0, port_addr_bit0_i = 1'b0;
  logic        port_addr_bit3_o, port_addr_bit3_oe_o, tb_bit2 = 1'b0;
  logic        link_n, alt = 1'b0, adp = 1'b0, up = 1'b1;
  logic [2:0]  mode_o;
  logic [4:0]  mgmt_addr_o;
  logic        speed_100_o, mac_legacy_fmt_o, slave_off_o, slave_link_ok_o;
  logic        test_serial_in_o, test_execute_o, test_clock_o;
  wire logic   port_addr_bit2_i = adp ? link_n : tb_bit2;
  logic [31:0] exp_q[$];
  int          err_count = 0, n_checks = 0, cycles = 0;

  mpfm_pin_mux DUT (.*);
  mpfm_slave_phy PHY (.clk_i(clk_i), .float_i(port_addr_bit3_o),
    .float_oe_i(port_addr_bit3_oe_o), .alt_i(alt), .link_up_i(up),
    .link_ok_n_o(link_n));

  always #2 clk_i = ~clk_i;

  // --------------------------------------------------------------------
  // checking
  // --------------------------------------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", n_checks, err_count);
    if (err_count == 0 && n_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] e);
    n_checks++;
    if (got !== e)
    begin
      err_count++;
      $display("Error %0t: read %h expected %h", $time, got, e);
    end
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (wb_ack_o === 1'b1 && wb_we_i === 1'b0)
      check(wb_dat_o, exp_q.pop_front());
    if (cycles == 3000)
    begin
      err_count++;
      results();
    end
  end

  // --------------------------------------------------------------------
  // stimulus
  // --------------------------------------------------------------------
  // a read hands its expected word in d
  task automatic wb(input logic w, input logic [3:0] a,
                    input logic [31:0] d, input logic [3:0] s);
    if (!w)
      exp_q.push_back(d);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= s;
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask

  // random enable gaps first, then enough running edges to settle
  task automatic idle();
    repeat (4)
    begin
      ce_i <= ($urandom_range(3) != 0);
      @(posedge clk_i);
    end
    ce_i <= 1'b1;
    repeat (6) @(posedge clk_i);
  endtask

  function automatic logic [31:0] stat(input logic [2:0] m,
                                       input logic [4:0] f,
                                       input logic [4:0] a);
    return {19'h0, a, f, m};
  endfunction

  initial
  begin
    logic [4:0] a;
    logic [4:0] b;
    logic       s;
    logic       l;
    logic       u;
    void'($urandom(74056));
    repeat (4) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 4'h0, 32'h0, 4'hf);
    wb(1'b1, 4'h4, 32'hffff_ffff, 4'hf);
    wb(1'b0, 4'h4, stat(3'h1, 5'h0, 5'h0), 4'hf);
    wb(1'b0, 4'hc, 32'h0, 4'hf);
    $display("registers done");
    for (int i = 0; i < 4; i++)
    begin
      a = 5'($urandom);
      s = 1'($urandom);
      {port_addr_bit4_i, port_addr_bit3_i, tb_bit2} <= a[4:2];
      {port_addr_bit1_i, port_addr_bit0_i} <= a[1:0];
      force_speed_select_i <= s;
      idle();
      wb(1'b0, 4'h4, stat(3'h1, {4'h0, s}, a), 4'hf);
    end
    $display("repeater done");
    l = 1'($urandom);
    u = 1'($urandom);
    // switch mode first so the repeater outputs never see the new pins
    wb(1'b1, 4'h0, 32'h7, 4'hf);
    force_speed_select_i <= l;
    port_addr_bit4_i <= ~a[4];
    adp <= 1'b1;
    alt <= 1'b1;
    up <= u;
    idle();
    wb(1'b0, 4'h4, stat(3'h2, {2'h0, u, l, s}, a), 4'hf);
    // no byte enable, so the write must be dropped
    wb(1'b1, 4'h0, 32'hf, 4'h0);
    wb(1'b0, 4'h0, 32'h7, 4'hf);
    wb(1'b1, 4'h0, 32'hf, 4'h1);
    idle();
    wb(1'b0, 4'h4, stat(3'h2, {3'h4, l, s}, a), 4'hf);
    alt <= 1'b0;
    wb(1'b1, 4'h0, 32'h1, 4'h1);
    force_speed_select_i <= ~l;
    idle();
    wb(1'b0, 4'h4, stat(3'h2, {3'h0, l, s}, a), 4'hf);
    $display("adapter done");
    adp <= 1'b0;
    test_enable_i <= 1'b1;
    for (int j = 0; j < 2; j++)
    begin
      b = 5'($urandom);
      {port_addr_bit4_i, port_addr_bit3_i, tb_bit2} <= b[4:2];
      {port_addr_bit1_i, port_addr_bit0_i} <= {j[0], b[0]};
      idle();
      wb(1'b0, 4'h4, stat(3'h4, {1'b0, j[0], 1'b0, l, s}, a), 4'hf);
    end
    $display("test mode done");
    results();
  end
endmodule

`default_nettype wire
